// >>> shared/monitor_i2c_pkg.sv
// Shared constants and types for the two-wire slave address front end.
// Assumes a 250 MHz system clock and a separate link sampling clock.
package monitor_i2c_pkg;

	// ************************************************************
	// Address layout
	// ************************************************************
	localparam logic [2:0] ADDR_FIXED = 3'h4;
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_VS = 2'h1;
	localparam logic [1:0] STRAP_SDA = 2'h2;
	localparam logic [1:0] STRAP_SCL = 2'h3;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int TIMEOUT_MS = 28;
	localparam int CLK_KHZ = 250000;
	// Milliseconds times kilohertz gives cycles directly.
	localparam int TIMEOUT_CYC = TIMEOUT_MS * CLK_KHZ;
	localparam int TMO_W = 23;

	// ************************************************************
	// Buffering
	// ************************************************************
	localparam int FIFO_DEPTH = 8;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed
	{
		logic is_addr;
		logic [7:0] data;
	} rx_word_s;

	localparam int FIFO_WIDTH = $bits(rx_word_s);

	typedef struct packed
	{
		logic o;
		logic oe_n;
	} od_drive_s;

	typedef enum logic [5:0]
	{
		ST_IDLE = 6'h01,
		ST_RX = 6'h02,
		ST_ACK = 6'h04,
		ST_TX = 6'h08,
		ST_MACK = 6'h10,
		ST_IGNORE = 6'h20
	} link_state_e;

endpackage

// >>> hdl/monitor_i2c_slave_addressing.sv
// Slave address front end of a two-wire bus: framing, strap address match, timeout.
// Assumes external pull-ups on both lines and a master that clocks the bus.
`timescale 1ns/1ps

// ************************************************************
// Receive buffer
// ************************************************************
module rx_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} fifo_st_s;

	fifo_st_s st_q;
	fifo_st_s st_d;
	logic push;
	logic pop;

	assign in_ready = st_q.cnt != (PW+1)'(DEPTH);
	assign out_valid = st_q.cnt != '0;
	assign out_data = st_q.mem[st_q.rp];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_comb
	begin
		st_d = st_q;
		if (push)
		begin
			st_d.mem[st_q.wp] = in_data;
			st_d.wp = st_q.wp + 1'b1;
		end
		if (pop)
		begin
			st_d.rp = st_q.rp + 1'b1;
		end
		st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end
endmodule

// ************************************************************
// Top level
// ************************************************************
module monitor_i2c_slave_addressing #(
	parameter int unsigned TIMEOUT_CYCLES = monitor_i2c_pkg::TIMEOUT_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic scl_in,
	output monitor_i2c_pkg::od_drive_s scl_drv,
	input wire logic sda_in,
	output monitor_i2c_pkg::od_drive_s sda_drv,
	input wire logic address_strap_low,
	input wire logic address_strap_high,
	output logic [6:0] own_addr,
	output logic rx_valid,
	input wire logic rx_ready,
	output monitor_i2c_pkg::rx_word_s rx_word
);
	import monitor_i2c_pkg::*;

	// Bit order of sampled vectors: strap high, strap low, clock, data.
	typedef struct packed
	{
		logic [1:0] rst;
		logic [3:0] s1;
		logic [3:0] s2;
		logic [3:0] s3;
		logic [3:0] f;
		logic [3:0] prev;
		logic [2:0] tmo;
		logic [1:0] full;
		link_state_e st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic is_addr;
		logic rw;
		logic nack;
		logic [1:0] eq_scl;
		logic [1:0] eq_sda;
		logic [6:0] addr;
		logic sda_oe_n;
		rx_word_s word;
		logic push_tgl;
	} link_st_s;

	typedef struct packed
	{
		logic [1:0] s1;
		logic [1:0] s2;
		logic [1:0] s3;
		logic [1:0] f;
		logic [TMO_W-1:0] tcnt;
		logic tmo_tgl;
		logic [2:0] rs;
		logic full;
	} sys_st_s;

	link_st_s link_q;
	link_st_s link_d;
	sys_st_s sys_q;
	sys_st_s sys_d;
	logic fifo_in_ready;
	logic fifo_in_valid;

	function automatic logic [1:0] strap_code(input logic eq_scl, input logic eq_sda,
		input logic level);
		logic [1:0] code;
		if (eq_scl)
		begin
			code = STRAP_SCL;
		end
		else if (eq_sda)
		begin
			code = STRAP_SDA;
		end
		else if (level)
		begin
			code = STRAP_VS;
		end
		else
		begin
			code = STRAP_GND;
		end
		return code;
	endfunction

	// ************************************************************
	// Link domain: pin filtering and protocol engine
	// ************************************************************
	always_comb
	begin
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic [6:0] match_addr;
		link_d = link_q;
		link_d.rst = {link_q.rst[0], sys_rst};
		link_d.s1 = {address_strap_high, address_strap_low, scl_in, sda_in};
		link_d.s2 = link_q.s1;
		link_d.s3 = link_q.s2;
		// A change is taken only once the second and third stages agree.
		link_d.f = (~(link_q.s2 ^ link_q.s3) & link_q.s3) | ((link_q.s2 ^ link_q.s3) & link_q.f);
		link_d.prev = link_q.f;
		link_d.tmo = {link_q.tmo[1:0], sys_q.tmo_tgl};
		link_d.full = {link_q.full[0], sys_q.full};
		scl = link_q.f[1];
		sda = link_q.f[0];
		scl_rise = scl & ~link_q.prev[1];
		scl_fall = ~scl & link_q.prev[1];
		start = link_q.prev[1] & scl & link_q.prev[0] & ~sda;
		stop = link_q.prev[1] & scl & ~link_q.prev[0] & sda;
		// Straps are compared against both lines throughout the address byte.
		if (link_q.st == ST_RX && link_q.is_addr)
		begin
			link_d.eq_scl = link_q.eq_scl & ~(link_q.f[3:2] ^ {2{scl}});
			link_d.eq_sda = link_q.eq_sda & ~(link_q.f[3:2] ^ {2{sda}});
		end
		match_addr = {ADDR_FIXED,
			strap_code(link_q.eq_scl[1], link_q.eq_sda[1], link_q.f[3]),
			strap_code(link_q.eq_scl[0], link_q.eq_sda[0], link_q.f[2])};
		unique case (link_q.st)
			ST_IDLE, ST_IGNORE:
			begin
				link_d.sda_oe_n = 1'b1;
			end
			ST_RX:
			begin
				if (scl_rise)
				begin
					link_d.sh = {link_q.sh[6:0], sda};
					link_d.cnt = link_q.cnt + 4'h1;
				end
				if (scl_fall && link_q.cnt == BYTE_BITS)
				begin
					link_d.cnt = 4'h0;
					link_d.is_addr = 1'b0;
					link_d.word = '{is_addr: link_q.is_addr, data: link_q.sh};
					if (link_q.is_addr)
					begin
						link_d.rw = link_q.sh[0];
						link_d.addr = match_addr;
					end
					if (link_q.is_addr ? link_q.sh[7:1] == match_addr : ~link_q.full[1])
					begin
						link_d.sda_oe_n = 1'b0;
						link_d.push_tgl = ~link_q.push_tgl;
						link_d.st = ST_ACK;
					end
					else
					begin
						link_d.st = ST_IGNORE;
					end
				end
			end
			ST_ACK:
			begin
				if (scl_fall)
				begin
					link_d.sda_oe_n = 1'b1;
					link_d.st = link_q.rw ? ST_TX : ST_RX;
				end
			end
			ST_TX:
			begin
				// No register data behind this front end: the line stays released.
				if (scl_rise)
				begin
					link_d.cnt = link_q.cnt + 4'h1;
				end
				if (scl_fall && link_q.cnt == BYTE_BITS)
				begin
					link_d.cnt = 4'h0;
					link_d.st = ST_MACK;
				end
			end
			ST_MACK:
			begin
				if (scl_rise)
				begin
					link_d.nack = sda;
				end
				if (scl_fall)
				begin
					link_d.st = link_q.nack ? ST_IGNORE : ST_TX;
				end
			end
			default:
			begin
				link_d.st = ST_IDLE;
				link_d.sda_oe_n = 1'b1;
			end
		endcase
		if (start)
		begin
			link_d.st = ST_RX;
			link_d.cnt = 4'h0;
			link_d.is_addr = 1'b1;
			link_d.eq_scl = 2'b11;
			link_d.eq_sda = 2'b11;
			link_d.sda_oe_n = 1'b1;
		end
		if (stop)
		begin
			link_d.st = ST_IDLE;
			link_d.cnt = 4'h0;
			link_d.sda_oe_n = 1'b1;
		end
		if (link_q.tmo[2] ^ link_q.tmo[1])
		begin
			link_d.st = ST_IDLE;
			link_d.cnt = 4'h0;
			link_d.sda_oe_n = 1'b1;
		end
	end

	always_ff @(posedge link_clk)
	begin
		if (link_q.rst[1])
		begin
			link_q <= '0;
			link_q.rst <= link_d.rst;
			link_q.s1 <= 4'hF;
			link_q.s2 <= 4'hF;
			link_q.s3 <= 4'hF;
			link_q.f <= 4'hF;
			link_q.prev <= 4'hF;
			link_q.tmo <= {3{sys_q.tmo_tgl}};
			link_q.st <= ST_IDLE;
			link_q.sda_oe_n <= 1'b1;
		end
		else
		begin
			link_q <= link_d;
		end
	end

	// ************************************************************
	// System domain: timeout and receive hand-off
	// ************************************************************
	always_comb
	begin
		logic low;
		sys_d = sys_q;
		sys_d.s1 = {scl_in, sda_in};
		sys_d.s2 = sys_q.s1;
		sys_d.s3 = sys_q.s2;
		sys_d.f = (~(sys_q.s2 ^ sys_q.s3) & sys_q.s3) | ((sys_q.s2 ^ sys_q.s3) & sys_q.f);
		low = ~&sys_q.f;
		sys_d.tcnt = low ? sys_q.tcnt + 1'b1 : '0;
		if (low && sys_q.tcnt == TMO_W'(TIMEOUT_CYCLES - 1))
		begin
			sys_d.tmo_tgl = ~sys_q.tmo_tgl;
			sys_d.tcnt = '0;
		end
		sys_d.rs = {sys_q.rs[1:0], link_q.push_tgl};
		sys_d.full = ~fifo_in_ready;
	end

	assign fifo_in_valid = sys_q.rs[2] ^ sys_q.rs[1];

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sys_q <= '0;
			sys_q.s1 <= 2'h3;
			sys_q.s2 <= 2'h3;
			sys_q.s3 <= 2'h3;
			sys_q.f <= 2'h3;
		end
		else
		begin
			sys_q <= sys_d;
		end
	end

	// The word stays put for a whole byte time, so it is safe to read here.
	rx_fifo #(
		.WIDTH(FIFO_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(link_q.word),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_word)
	);

	// ************************************************************
	// Pins
	// ************************************************************
	assign scl_drv = '{o: 1'b0, oe_n: 1'b1};
	assign sda_drv = '{o: 1'b0, oe_n: link_q.sda_oe_n};
	assign own_addr = link_q.addr;
endmodule

// >>> sim/monitor_i2c_slave_addressing_assertions.sv
// Protocol checker for the two-wire slave front end.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module monitor_i2c_slave_addressing_assertions
	import monitor_i2c_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 200
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic scl_in,
	input wire od_drive_s scl_drv,
	input wire logic sda_in,
	input wire od_drive_s sda_drv,
	input wire logic [6:0] own_addr,
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire rx_word_s rx_word
);
	int unsigned low_q;
	always_ff @(posedge clk)
	begin
		low_q <= (sys_rst || scl_in) ? 0 : low_q + 1;
	end
	a_scl_released: assert property (@(posedge clk) disable iff (sys_rst) scl_drv.oe_n)
		else $error("clock line pulled");
	a_sda_open_drain: assert property (@(posedge clk) disable iff (sys_rst) !sda_drv.o)
		else $error("data line driven high");
	a_sda_moves_low: assert property (@(posedge link_clk) disable iff (sys_rst)
		$changed(sda_drv.oe_n) |-> !scl_in) else $error("data drive changed with clock high");
	a_ack_stands: assert property (@(posedge link_clk) disable iff (sys_rst)
		$fell(sda_drv.oe_n) |=> !sda_drv.oe_n [*8]) else $error("acknowledge too short");
	a_tmo_release: assert property (@(posedge clk) disable iff (sys_rst)
		low_q > TIMEOUT_CYCLES + 40 |-> sda_drv.oe_n) else $error("no timeout release");
	a_fifo_holds: assert property (@(posedge clk) disable iff (sys_rst)
		rx_valid && !rx_ready |=> rx_valid && $stable(rx_word)) else $error("word lost");
	a_addr_word: assert property (@(posedge clk) disable iff (sys_rst)
		rx_valid && rx_word.is_addr |-> rx_word.data[7:1] == own_addr)
		else $error("address word wrong");
	a_own_fixed: assert property (@(posedge link_clk) disable iff (sys_rst)
		$changed(own_addr) |-> own_addr[6:4] == ADDR_FIXED) else $error("bad fixed bits");
endmodule

// >>> sim/i2c_master_model.sv
// Bus master model clocking the two-wire link.
// Assumes open-drain wiring with pull-ups is resolved by the bench.
`timescale 1ns/1ps
module i2c_master_model (
	input wire logic link_clk,
	input wire logic sda_in,
	output logic scl_o,
	output logic sda_o
);
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge link_clk);
		#1;
	endtask
	task automatic start;
		sda_o = 1'b1;
		hold(8);
		scl_o = 1'b1;
		hold(8);
		sda_o = 1'b0;
		hold(8);
		scl_o = 1'b0;
	endtask
	task automatic stop;
		sda_o = 1'b0;
		hold(8);
		scl_o = 1'b1;
		hold(8);
		sda_o = 1'b1;
		hold(8);
	endtask
	// The stall stretches the low clock before the ninth pulse.
	task automatic send(input logic [7:0] b, input int stall, output logic ack);
		for (int i = 7; i >= 0; i--)
		begin
			sda_o = b[i];
			hold(8);
			scl_o = 1'b1;
			hold(8);
			scl_o = 1'b0;
		end
		sda_o = 1'b1;
		hold(8 + stall);
		scl_o = 1'b1;
		hold(4);
		ack = !sda_in;
		hold(4);
		scl_o = 1'b0;
	endtask
endmodule

// >>> sim/tb_monitor_i2c_slave_addressing.sv
// Self-checking bench for the two-wire slave front end.
// Assumes the master model and the checker are compiled first.
`timescale 1ns/1ps
module tb_monitor_i2c_slave_addressing;
	import monitor_i2c_pkg::*;
	logic clk = 0, link_clk = 0, sys_rst = 1, rx_ready = 0;
	logic m_scl, m_sda, scl, sda, ack, rx_valid;
	logic [1:0] sl = 0, sh = 0;
	logic [6:0] own_addr;
	od_drive_s scl_drv, sda_drv;
	rx_word_s rx_word;
	int err_count = 0, tests_run = 0, cyc = 0;
	assign scl = m_scl & scl_drv.oe_n;
	assign sda = m_sda & sda_drv.oe_n;
	logic strap_lo, strap_hi;
	// Straps set to STRAP_SDA or STRAP_SCL follow the bus lines directly so the pins see every edge of them.
	assign strap_lo = sl == STRAP_GND ? 1'b0 : sl == STRAP_VS ? 1'b1 : sl == STRAP_SDA ? sda : scl;
	assign strap_hi = sh == STRAP_GND ? 1'b0 : sh == STRAP_VS ? 1'b1 : sh == STRAP_SDA ? sda : scl;
	i2c_master_model u_i2c_master_model (.link_clk(link_clk), .sda_in(sda), .scl_o(m_scl),
		.sda_o(m_sda));
	// Long enough that a byte of zeros never trips it, short enough to test.
	monitor_i2c_slave_addressing #(.TIMEOUT_CYCLES(2000)) u_monitor_i2c_slave_addressing (
		.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_in(scl), .scl_drv(scl_drv),
		.sda_in(sda), .sda_drv(sda_drv), .address_strap_low(strap_lo),
		.address_strap_high(strap_hi), .own_addr(own_addr), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .rx_word(rx_word));
	always #2 clk = ~clk;
	always #7.5 link_clk = ~link_clk;
	task automatic stop_test;
		if (err_count == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 50000)
		begin
			err_count++;
			stop_test;
		end
	end
	task automatic check(input logic [8:0] got, input logic [8:0] exp, input string msg);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic pop(input logic [8:0] exp);
		@(posedge clk) #1;
		check(rx_valid, 1, "fifo empty");
		check(rx_word, exp, "fifo word");
		rx_ready = 1;
		@(posedge clk) #1 rx_ready = 0;
	endtask
	task automatic send(input logic [7:0] b, input int stall, input logic exp, string msg);
		u_i2c_master_model.send(b, stall, ack);
		check(ack, exp, msg);
	endtask
	task automatic t_addr;
		for (int a = 0; a < 16; a++)
		begin
			@(posedge clk) #1 {sh, sl} = a[3:0];
			u_i2c_master_model.start();
			send({ADDR_FIXED, a[3:0], a[0]}, 0, 1, "addr ack");
			u_i2c_master_model.stop();
			check(own_addr, {ADDR_FIXED, a[3:0]}, "own addr");
			pop({1'b1, ADDR_FIXED, a[3:0], a[0]});
		end
	endtask
	task automatic t_miss;
		@(posedge clk) #1 {sh, sl} = 4'h0;
		u_i2c_master_model.start();
		send(8'h82, 0, 0, "miss ack");
		send(8'h80, 0, 0, "ignore");
		u_i2c_master_model.stop();
		check(rx_valid, 0, "miss push");
	endtask
	task automatic t_fill;
		u_i2c_master_model.start();
		send(8'h80, 0, 1, "fill addr");
		for (int i = 0; i < 7; i++)
			send({i[3:0], 4'hC}, 0, 1, "fill ack");
		send(8'hA5, 0, 0, "full nack");
		u_i2c_master_model.stop();
		pop(9'h180);
		for (int i = 0; i < 7; i++)
			pop({1'b0, i[3:0], 4'hC});
		@(posedge clk) #1 check(rx_valid, 0, "drained");
	endtask
	task automatic t_tmo;
		u_i2c_master_model.start();
		send(8'h80, 700, 0, "timeout");
		send(8'h80, 0, 0, "idle after");
		u_i2c_master_model.stop();
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		#1 sys_rst = 0;
		repeat (50) @(posedge clk);
		t_addr();
		t_miss();
		t_fill();
		t_tmo();
		stop_test;
	end
endmodule
bind monitor_i2c_slave_addressing monitor_i2c_slave_addressing_assertions #(
	.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_monitor_i2c_slave_addressing_assertions (
	.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk), .scl_in(scl_in), .scl_drv(scl_drv),
	.sda_in(sda_in), .sda_drv(sda_drv), .own_addr(own_addr), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .rx_word(rx_word));
